// file: pkg/rtc_store_pkg.sv
`default_nettype none
package rtc_store_pkg;
	// store window
	localparam int          ADDR_W     = 13;
	localparam int          MEM_BYTES  = 8192;
	localparam logic [31:0] STORE_BASE = 32'hfffc0000;
	localparam logic [31:0] STATION_UPPER_ADDR = 32'hfffc1f2c;
	localparam logic [31:0] STATION_LOWER_ADDR = 32'hfffc1f30;
	localparam logic [12:0] STATION_UPPER_OFS  = STATION_UPPER_ADDR[12:0];
	localparam logic [12:0] STATION_LOWER_OFS  = STATION_LOWER_ADDR[12:0];
	localparam logic [2:0]  INIT_BYTES = 3'h6;
	// arbitrary neutral seven-nibble prefix
	localparam logic [27:0] STATION_PREFIX = 28'h1234560;
	// clock byte map at the top of the store
	localparam logic [12:0] CTRL_OFS = 13'h1ff8;
	localparam logic [12:0] SEC_OFS  = 13'h1ff9;
	localparam int          HALT_BIT = 7;
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam int F_SEC   = 0;
	localparam int F_MIN   = 1;
	localparam int F_HOUR  = 2;
	localparam int F_DOW   = 3;
	localparam int F_DATE  = 4;
	localparam int F_MONTH = 5;
	localparam int F_YEAR  = 6;
	localparam int N_FIELDS = 7;
	// bcd limits and reset values
	localparam logic [7:0] BCD_ZERO  = 8'h00;
	localparam logic [7:0] BCD_ONE   = 8'h01;
	localparam logic [7:0] SEC_MAX   = 8'h59;
	localparam logic [7:0] HOUR_MAX  = 8'h23;
	localparam logic [7:0] DOW_MAX   = 8'h07;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [7:0] FEB       = 8'h02;
	localparam logic [7:0] DAYS_28   = 8'h28;
	localparam logic [7:0] DAYS_29   = 8'h29;
	localparam logic [7:0] DAYS_30   = 8'h30;
	localparam logic [7:0] DAYS_31   = 8'h31;
	// access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// timing
	localparam int SECOND_NS   = 1000000000;
	localparam int CLK_NS      = 40;
	localparam int TICK_CYCLES = SECOND_NS / CLK_NS;
	localparam int TICK_W      = 25;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_INIT = 4'b0010,
		ST_XFER = 4'b0100,
		ST_DONE = 4'b1000
	} seq_state_type;
endpackage
`default_nettype wire

// file: core/battery_backed_clock_ram.sv
`timescale 1ns/1ns
`default_nettype none
module battery_backed_clock_ram #(
	parameter int TICK_CYCLES = rtc_store_pkg::TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        bus_req,
	input  wire logic        bus_wr,
	input  wire logic [12:0] bus_addr,
	input  wire logic [1:0]  bus_size,
	input  wire logic [31:0] bus_wdata,
	output logic      [31:0] bus_rdata,
	output logic             bus_ack,
	input  wire logic        power_fail_n,
	input  wire logic [19:0] board_serial,
	output logic             write_blocked
);
	// bcd increment of a two-digit value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// wrap to the low value after the top one
	function automatic logic [7:0] roll(input logic [7:0] v, input logic [7:0] top,
			input logic [7:0] low);
		roll = (v == top) ? low : bcd_inc(v);
	endfunction

	// last date of the month; a bcd year is a multiple of four when tens
	// even with ones 0/4/8, or tens odd with ones 2/6
	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h04, 8'h06, 8'h09, 8'h11: month_days = rtc_store_pkg::DAYS_30;
			rtc_store_pkg::FEB: month_days = leap ? rtc_store_pkg::DAYS_29
				: rtc_store_pkg::DAYS_28;
			default: month_days = rtc_store_pkg::DAYS_31;
		endcase
	endfunction

	function automatic logic is_time(input logic [12:0] a);
		is_time = (a >= rtc_store_pkg::SEC_OFS);
	endfunction

	rtc_store_pkg::seq_state_type state_reg, state_next;
	logic [12:0] addr_reg,   addr_next;
	logic [2:0]  idx_reg,    idx_next;
	logic [2:0]  nbytes_reg, nbytes_next;
	logic        wr_reg,     wr_next;
	logic [31:0] wshift_reg, wshift_next;
	logic [31:0] data_reg,   data_next;
	logic [7:0]  time_reg [rtc_store_pkg::N_FIELDS];
	logic [7:0]  time_next [rtc_store_pkg::N_FIELDS];
	logic [7:0]  ctrl_reg,   ctrl_next;
	logic [rtc_store_pkg::TICK_W-1:0] tick_reg, tick_next;
	logic        pf_meta_reg, pf_sync_reg;
	logic [19:0] serial_meta_reg, serial_sync_reg;
	logic [7:0]  mem_reg [rtc_store_pkg::MEM_BYTES];
	logic [12:0] cur_addr;
	logic [2:0]  fidx;
	logic [7:0]  rd_byte, wr_byte, held_byte;
	logic [47:0] station_sh;
	logic        byte_we, mem_we, time_we, ctrl_we, tick, run;
	logic        c_min, c_hour, c_day, c_month, c_year;

	// pins from off-chip pass two flops before anything looks at them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pf_meta_reg     <= 1'b0;
			pf_sync_reg     <= 1'b0;
			serial_meta_reg <= 20'h00000;
			serial_sync_reg <= 20'h00000;
		end else if (ce) begin
			pf_meta_reg     <= power_fail_n;
			pf_sync_reg     <= pf_meta_reg;
			serial_meta_reg <= board_serial;
			serial_sync_reg <= serial_meta_reg;
		end
	end

	// byte lane of the current single-byte cycle
	always_comb begin
		cur_addr   = addr_reg + 13'(idx_reg);
		fidx       = 3'(cur_addr - rtc_store_pkg::SEC_OFS);
		station_sh = {rtc_store_pkg::STATION_PREFIX, serial_sync_reg} << {idx_reg, 3'b000};
		held_byte  = mem_reg[cur_addr];
		if (is_time(cur_addr)) begin
			rd_byte = time_reg[fidx];
		end else if (cur_addr == rtc_store_pkg::CTRL_OFS) begin
			rd_byte = ctrl_reg;
		end else begin
			rd_byte = held_byte;
		end
		wr_byte = (state_reg == rtc_store_pkg::ST_INIT) ? station_sh[47:40] : wshift_reg[31:24];
		// a failing supply drops the write but the cycle still completes
		byte_we = !pf_sync_reg ? 1'b0 :
			((state_reg == rtc_store_pkg::ST_XFER) && wr_reg)
			|| (state_reg == rtc_store_pkg::ST_INIT);
		time_we = byte_we && is_time(cur_addr);
		ctrl_we = byte_we && (cur_addr == rtc_store_pkg::CTRL_OFS);
		mem_we  = byte_we && !is_time(cur_addr) && (cur_addr != rtc_store_pkg::CTRL_OFS);
	end

	// access sequencer: one store byte per cycle, ack after the last
	always_comb begin
		state_next  = state_reg;
		addr_next   = addr_reg;
		idx_next    = idx_reg;
		nbytes_next = nbytes_reg;
		wr_next     = wr_reg;
		wshift_next = wshift_reg;
		data_next   = data_reg;
		case (state_reg)
			rtc_store_pkg::ST_INIT: begin
				// restore the station address; hold each byte until the supply flops
				// show power good, else the blocked first bytes would be skipped
				if (pf_sync_reg && idx_reg == rtc_store_pkg::INIT_BYTES - 3'h1) begin
					state_next = rtc_store_pkg::ST_IDLE;
					idx_next   = 3'h0;
				end else if (pf_sync_reg) begin
					idx_next = idx_reg + 3'h1;
				end
			end
			rtc_store_pkg::ST_IDLE: begin
				if (bus_req) begin
					state_next = rtc_store_pkg::ST_XFER;
					addr_next  = bus_addr;
					wr_next    = bus_wr;
					idx_next   = 3'h0;
					data_next  = 32'h00000000;
					case (bus_size)
						rtc_store_pkg::SIZE_BYTE: begin
							nbytes_next = 3'h1;
							wshift_next = {bus_wdata[7:0], 24'h000000};
						end
						rtc_store_pkg::SIZE_HALF: begin
							nbytes_next = 3'h2;
							wshift_next = {bus_wdata[15:0], 16'h0000};
						end
						default: begin
							nbytes_next = 3'h4;
							wshift_next = bus_wdata;
						end
					endcase
				end
			end
			rtc_store_pkg::ST_XFER: begin
				// first byte lands most significant, as on a big-endian bus
				data_next   = {data_reg[23:0], rd_byte};
				wshift_next = {wshift_reg[23:0], 8'h00};
				if (idx_reg == nbytes_reg - 3'h1) begin
					state_next = rtc_store_pkg::ST_DONE;
				end else begin
					idx_next = idx_reg + 3'h1;
				end
			end
			rtc_store_pkg::ST_DONE: begin
				state_next = rtc_store_pkg::ST_IDLE;
			end
			default: begin
				state_next = rtc_store_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= rtc_store_pkg::ST_INIT;
			addr_reg   <= rtc_store_pkg::STATION_UPPER_OFS;
			idx_reg    <= 3'h0;
			nbytes_reg <= 3'h1;
			wr_reg     <= 1'b0;
			wshift_reg <= 32'h00000000;
			data_reg   <= 32'h00000000;
		end else if (ce) begin
			state_reg  <= state_next;
			addr_reg   <= addr_next;
			idx_reg    <= idx_next;
			nbytes_reg <= nbytes_next;
			wr_reg     <= wr_next;
			wshift_reg <= wshift_next;
			data_reg   <= data_next;
		end
	end

	// backed store keeps its contents across reset, so it has none
	always_ff @(posedge clk) begin
		if (ce && mem_we) begin
			mem_reg[cur_addr] <= wr_byte;
		end
	end

	// timekeeping: seconds tick, bcd cascade, bus writes win over the tick
	always_comb begin
		run       = !ctrl_reg[rtc_store_pkg::HALT_BIT];
		tick      = (tick_reg == rtc_store_pkg::TICK_W'(TICK_CYCLES - 1));
		tick_next = tick ? '0 : tick_reg + 1'b1;
		time_next = time_reg;
		ctrl_next = ctrl_reg;
		c_min     = time_reg[rtc_store_pkg::F_SEC] == rtc_store_pkg::SEC_MAX;
		c_hour    = c_min && time_reg[rtc_store_pkg::F_MIN] == rtc_store_pkg::SEC_MAX;
		c_day     = c_hour && time_reg[rtc_store_pkg::F_HOUR] == rtc_store_pkg::HOUR_MAX;
		c_month   = c_day && time_reg[rtc_store_pkg::F_DATE]
			== month_days(time_reg[rtc_store_pkg::F_MONTH], time_reg[rtc_store_pkg::F_YEAR]);
		c_year    = c_month && time_reg[rtc_store_pkg::F_MONTH] == rtc_store_pkg::MONTH_MAX;
		// no request line leaves this block; software polls the fields
		if (tick && run) begin
			time_next[rtc_store_pkg::F_SEC] = roll(time_reg[rtc_store_pkg::F_SEC],
				rtc_store_pkg::SEC_MAX, rtc_store_pkg::BCD_ZERO);
			if (c_min) begin
				time_next[rtc_store_pkg::F_MIN] = roll(time_reg[rtc_store_pkg::F_MIN],
					rtc_store_pkg::SEC_MAX, rtc_store_pkg::BCD_ZERO);
			end
			if (c_hour) begin
				time_next[rtc_store_pkg::F_HOUR] = roll(time_reg[rtc_store_pkg::F_HOUR],
					rtc_store_pkg::HOUR_MAX, rtc_store_pkg::BCD_ZERO);
			end
			if (c_day) begin
				time_next[rtc_store_pkg::F_DOW] = roll(time_reg[rtc_store_pkg::F_DOW],
					rtc_store_pkg::DOW_MAX, rtc_store_pkg::BCD_ONE);
				time_next[rtc_store_pkg::F_DATE] = roll(time_reg[rtc_store_pkg::F_DATE],
					month_days(time_reg[rtc_store_pkg::F_MONTH],
					time_reg[rtc_store_pkg::F_YEAR]), rtc_store_pkg::BCD_ONE);
			end
			if (c_month) begin
				time_next[rtc_store_pkg::F_MONTH] = roll(time_reg[rtc_store_pkg::F_MONTH],
					rtc_store_pkg::MONTH_MAX, rtc_store_pkg::BCD_ONE);
			end
			if (c_year) begin
				time_next[rtc_store_pkg::F_YEAR] = roll(time_reg[rtc_store_pkg::F_YEAR],
					rtc_store_pkg::YEAR_MAX, rtc_store_pkg::BCD_ZERO);
			end
		end
		if (time_we) begin
			time_next[fidx] = wr_byte;
		end
		if (ctrl_we) begin
			ctrl_next = wr_byte;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			time_reg <= '{rtc_store_pkg::BCD_ZERO, rtc_store_pkg::BCD_ZERO,
				rtc_store_pkg::BCD_ZERO, rtc_store_pkg::BCD_ONE, rtc_store_pkg::BCD_ONE,
				rtc_store_pkg::BCD_ONE, rtc_store_pkg::BCD_ZERO};
			ctrl_reg <= rtc_store_pkg::CTRL_RST;
			tick_reg <= '0;
		end else if (ce) begin
			time_reg <= time_next;
			ctrl_reg <= ctrl_next;
			tick_reg <= tick_next;
		end
	end

	assign bus_ack       = (state_reg == rtc_store_pkg::ST_DONE);
	assign bus_rdata     = data_reg;
	assign write_blocked = !pf_sync_reg;

	chk_ack_single_cycle: assert property (@(posedge clk) disable iff (!rst_n)
		bus_ack && ce |=> !bus_ack) else $error("ack held past one cycle");
	chk_byte_access_len: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state_reg == rtc_store_pkg::ST_IDLE && bus_req
		&& bus_size == rtc_store_pkg::SIZE_BYTE) ##1 ce |=> bus_ack)
		else $error("byte access not acked after one byte");
	chk_half_access_len: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state_reg == rtc_store_pkg::ST_IDLE && bus_req
		&& bus_size == rtc_store_pkg::SIZE_HALF) ##1 ce[*2] |=> bus_ack)
		else $error("half access not acked after two bytes");
	chk_word_access_len: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && state_reg == rtc_store_pkg::ST_IDLE && bus_req
		&& bus_size == rtc_store_pkg::SIZE_WORD) ##1 (ce && !bus_ack)[*4] |=> bus_ack)
		else $error("word access not acked after four bytes");
	chk_power_fail_block: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !pf_sync_reg && state_reg == rtc_store_pkg::ST_XFER
		|=> mem_reg[$past(cur_addr)] == $past(held_byte))
		else $error("store written during power failure");
	chk_second_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		ce && tick && run && !time_we && time_reg[rtc_store_pkg::F_SEC] == 8'h59
		|=> time_reg[rtc_store_pkg::F_SEC] == 8'h00 && $changed(time_reg[rtc_store_pkg::F_MIN]))
		else $error("seconds did not wrap into minutes");
	chk_hour_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		ce && tick && run && !time_we && c_day |=> time_reg[rtc_store_pkg::F_HOUR] == 8'h00)
		else $error("hour did not wrap at 23");
	chk_month_end: assert property (@(posedge clk) disable iff (!rst_n)
		ce && tick && run && !time_we && c_month
		|=> time_reg[rtc_store_pkg::F_DATE] == 8'h01 && $changed(time_reg[rtc_store_pkg::F_MONTH]))
		else $error("date did not roll at month end");
endmodule
`default_nettype wire

// file: test/bus_host.sv
`timescale 1ns/1ns
`default_nettype none
module bus_host (
	input  wire logic        clk,
	input  wire logic        bus_ack,
	input  wire logic [31:0] bus_rdata,
	output logic             bus_req,
	output logic             bus_wr,
	output logic      [12:0] bus_addr,
	output logic      [1:0]  bus_size,
	output logic      [31:0] bus_wdata
);
	// quiet bus at time zero
	initial begin
		bus_req = 1'b0;
		bus_wr = 1'b0;
		bus_addr = 13'h0000;
		bus_size = 2'h0;
		bus_wdata = 32'h00000000;
	end

	// one access, held whole until the ack cycle; answer taken in that cycle
	task automatic access(input logic w, input logic [12:0] a, input logic [1:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h00000000;
		@(posedge clk);
		bus_req <= 1'b1;
		bus_wr <= w;
		bus_addr <= a;
		bus_size <= s;
		bus_wdata <= d;
		for (n = 0; n < 16 && !ok; n++) begin
			@(negedge clk);
			if (bus_ack === 1'b1) begin
				ok = 1'b1;
				q = bus_rdata;
			end
		end
		@(posedge clk);
		bus_req <= 1'b0;
		bus_wdata <= ~d; // released data never shows the last value
	endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int          TICKS  = 16;
	localparam logic [19:0] SERIAL = 20'h5a3c7;
	logic        clk;
	logic        rst_n;
	logic        ce;
	logic        power_fail_n;
	logic [19:0] board_serial;
	logic        bus_req;
	logic        bus_wr;
	logic [12:0] bus_addr;
	logic [1:0]  bus_size;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	logic        bus_ack;
	logic        write_blocked;
	logic [31:0] q;
	int          error_cnt;
	int          tests_run;
	int          i;
	// start date, month, year then expected date, month, year after one day
	logic [47:0] cal [4] = '{48'h280201010301, 48'h280204290204,
		48'h300401010501, 48'h311299010100};

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	battery_backed_clock_ram #(.TICK_CYCLES(TICKS)) u_battery_backed_clock_ram (
		.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .bus_wr(bus_wr),
		.bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .power_fail_n(power_fail_n),
		.board_serial(board_serial), .write_blocked(write_blocked));

	bus_host u_bus_host (
		.clk(clk), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_req(bus_req),
		.bus_wr(bus_wr), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata));

	task automatic end_of_test();
		$display("mismatches %0d of %0d compares", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a missing ack counts as a mismatch and ends the run
	task automatic xfer(input logic w, input logic [12:0] a, input logic [1:0] s,
		input logic [31:0] d);
		logic ok;
		u_bus_host.access(w, a, s, d, q, ok);
		if (!ok) begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic rdc(input logic [12:0] a, input logic [1:0] s, input logic [31:0] e);
		xfer(1'b0, a, s, 32'h00000000);
		check(q, e);
	endtask

	initial begin
		error_cnt = 0;
		tests_run = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		power_fail_n = 1'b1;
		board_serial = SERIAL;
		repeat (5) @(posedge clk);
		check({31'h0, write_blocked}, 32'h1);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check({31'h0, write_blocked}, 32'h0);
		rdc(rtc_store_pkg::STATION_UPPER_OFS, rtc_store_pkg::SIZE_WORD,
			{rtc_store_pkg::STATION_PREFIX, SERIAL[19:16]});
		rdc(rtc_store_pkg::STATION_LOWER_OFS, rtc_store_pkg::SIZE_HALF,
			{16'h0000, SERIAL[15:0]});
		// wide write split into ascending bytes, read back one byte at a time
		xfer(1'b1, 13'h0100, rtc_store_pkg::SIZE_WORD, 32'hc1d2e3f4);
		for (i = 0; i < 4; i++) begin
			rdc(13'h0100 + 13'(i), rtc_store_pkg::SIZE_BYTE,
				(32'hc1d2e3f4 >> (24 - 8 * i)) & 32'h000000ff);
		end
		xfer(1'b1, 13'h0102, rtc_store_pkg::SIZE_HALF, 32'h00005566);
		rdc(13'h0100, rtc_store_pkg::SIZE_WORD, 32'hc1d25566);
		// supply failing: writes dropped, reads still served
		power_fail_n <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check({31'h0, write_blocked}, 32'h1);
		xfer(1'b1, 13'h0100, rtc_store_pkg::SIZE_WORD, 32'h00000000);
		rdc(13'h0100, rtc_store_pkg::SIZE_WORD, 32'hc1d25566);
		power_fail_n <= 1'b1;
		repeat (3) @(posedge clk);
		// a low clock enable freezes the sequencer: the access waits, data intact
		fork
			rdc(13'h0100, rtc_store_pkg::SIZE_WORD, 32'hc1d25566);
			begin
				ce <= 1'b0;
				repeat (6) @(posedge clk);
				ce <= 1'b1;
				@(negedge clk);
				check({31'h0, bus_ack}, 32'h0);
			end
		join
		// set 23:59:59 on a month end or on a leap-year 28 Feb, run one to two ticks, halt and read
		for (i = 0; i < 4; i++) begin
			xfer(1'b1, rtc_store_pkg::CTRL_OFS, rtc_store_pkg::SIZE_BYTE, 32'h00000080);
			xfer(1'b1, rtc_store_pkg::SEC_OFS, rtc_store_pkg::SIZE_WORD, 32'h59592301);
			xfer(1'b1, 13'h1ffc, rtc_store_pkg::SIZE_WORD, {8'h01, cal[i][47:24]});
			xfer(1'b1, rtc_store_pkg::CTRL_OFS, rtc_store_pkg::SIZE_BYTE, 32'h00000000);
			repeat (20) @(posedge clk);
			xfer(1'b1, rtc_store_pkg::CTRL_OFS, rtc_store_pkg::SIZE_BYTE, 32'h00000080);
			rdc(13'h1ffc, rtc_store_pkg::SIZE_WORD, {8'h02, cal[i][23:0]});
			xfer(1'b0, rtc_store_pkg::SEC_OFS, rtc_store_pkg::SIZE_WORD, 32'h00000000);
			check({16'h0000, q[23:8]}, 32'h00000000);
		end
		// a second reset: store bytes survive, clock and station restart
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdc(13'h0100, rtc_store_pkg::SIZE_WORD, 32'hc1d25566);
		rdc(13'h1ffc, rtc_store_pkg::SIZE_WORD, 32'h01010100);
		rdc(rtc_store_pkg::STATION_LOWER_OFS, rtc_store_pkg::SIZE_HALF,
			{16'h0000, SERIAL[15:0]});
		end_of_test();
	end
endmodule
`default_nettype wire
